// file: logic/lfa_core.sv
// Accumulator, flags, pointer pairs and file registers with their single-cycle operations
//
// Added by the designer: the strobed register port and the register offsets.
module lfa_core #(
   parameter int FILE_DEPTH = lfa_pkg::FILE_DEPTH
) (
   input  wire logic                   CLK,
   input  wire logic                   RST_N,
   input  wire logic                   OP_VALID,
   input  wire lfa_pkg::lfa_op_t       OP_CODE,
   input  wire logic [7:0]             OP_LIT,
   input  wire logic [6:0]             OP_FADDR,
   input  wire logic                   OP_DEST,
   input  wire logic [2:0]             OP_BIT,
   input  wire logic                   OP_PTR_SEL,
   input  wire logic [9:0]             ADDR,
   input  wire logic [31:0]            WR_DATA,
   input  wire logic                   WR_EN,
   input  wire logic                   RD_EN,
   output logic      [31:0]            RD_DATA,
   output logic      [7:0]             ACC,
   output logic                        FLAG_C,
   output logic                        FLAG_DCY,
   output logic                        FLAG_Z,
   output logic      [15:0]            PTR0,
   output logic      [15:0]            PTR1,
   output logic                        OP_DONE
);
   logic [7:0]  file_mem [FILE_DEPTH];
   logic [7:0]  acc_ff;
   logic [7:0]  nxt_acc;
   logic        c_ff;
   logic        nxt_c;
   logic        dcy_ff;
   logic        nxt_dcy;
   logic        z_ff;
   logic        nxt_z;
   logic [15:0] ptr0_ff;
   logic [15:0] nxt_ptr0;
   logic [15:0] ptr1_ff;
   logic [15:0] nxt_ptr1;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic        done_ff;
   logic        nxt_done;
   logic        mem_we;
   logic [6:0]  mem_waddr;
   logic [7:0]  mem_wdata;
   logic [7:0]  file_rd;
   logic [7:0]  bus_file_rd;
   logic        bus_in_file;
   logic [6:0]  bus_findex;
   logic [7:0]  add_b;
   logic        add_cin;
   logic [7:0]  add_sum;
   logic        add_c;
   logic        add_dcy;
   logic [15:0] ptr_in;
   logic [15:0] ptr_res;
   logic [7:0]  res;
   logic        res_to_dest;

   assign file_rd     = file_mem[OP_FADDR];
   // File window answers only on word-aligned offsets, the rest read zero
   assign bus_in_file = ADDR[9] && (ADDR[1:0] == 2'h0);
   assign bus_findex  = ADDR[8:2];
   assign bus_file_rd = file_mem[bus_findex];

   // One adder serves literal add, file add and add with carry
   assign add_b   = (OP_CODE == lfa_pkg::OP_ADD_IMMEDIATE) ? OP_LIT : file_rd;
   assign add_cin = (OP_CODE == lfa_pkg::OP_ADD_FILE_WITH_CARRY) ? c_ff : 1'b0;
   assign ptr_in  = OP_PTR_SEL ? ptr1_ff : ptr0_ff;

   lfa_add8 u_add8 (
      .a     (acc_ff),
      .b     (add_b),
      .cin   (add_cin),
      .sum   (add_sum),
      .cout  (add_c),
      .dcout (add_dcy)
   );

   lfa_ptr_add u_ptr_add (
      .ptr (ptr_in),
      .lit (OP_LIT[5:0]),
      .res (ptr_res)
   );

   always_comb begin
      nxt_acc     = acc_ff;
      nxt_c       = c_ff;
      nxt_dcy     = dcy_ff;
      nxt_z       = z_ff;
      nxt_ptr0    = ptr0_ff;
      nxt_ptr1    = ptr1_ff;
      nxt_rdata   = 32'h00000000;
      nxt_done    = 1'b0;
      mem_we      = 1'b0;
      mem_waddr   = bus_findex;
      mem_wdata   = WR_DATA[7:0];
      res         = 8'h00;
      res_to_dest = 1'b0;

      // Reads show the state before any update in the same cycle
      if (RD_EN) begin
         if (bus_in_file) begin
            nxt_rdata = {24'h000000, bus_file_rd};
         end else begin
            case (ADDR)
               lfa_pkg::OFS_ACC:    nxt_rdata = {24'h000000, acc_ff};
               lfa_pkg::OFS_STATUS: nxt_rdata = {29'h00000000, z_ff, dcy_ff, c_ff};
               lfa_pkg::OFS_PTR0:   nxt_rdata = {16'h0000, ptr0_ff};
               lfa_pkg::OFS_PTR1:   nxt_rdata = {16'h0000, ptr1_ff};
               default:             nxt_rdata = 32'h00000000;
            endcase
         end
      end

      if (WR_EN) begin
         if (bus_in_file) begin
            mem_we = 1'b1;
         end else begin
            case (ADDR)
               lfa_pkg::OFS_ACC: nxt_acc = WR_DATA[7:0];
               lfa_pkg::OFS_STATUS: begin
                  nxt_c   = WR_DATA[lfa_pkg::POS_C];
                  nxt_dcy = WR_DATA[lfa_pkg::POS_DCY];
                  nxt_z   = WR_DATA[lfa_pkg::POS_Z];
               end
               lfa_pkg::OFS_PTR0: nxt_ptr0 = WR_DATA[15:0];
               lfa_pkg::OFS_PTR1: nxt_ptr1 = WR_DATA[15:0];
               default: ;
            endcase
         end
      end

      // An operation overrides a bus write to the same target in the same cycle
      if (OP_VALID) begin
         nxt_done = 1'b1;
         case (OP_CODE)
            lfa_pkg::OP_AND_IMMEDIATE: begin
               res     = acc_ff & OP_LIT;
               nxt_acc = res;
               nxt_z   = (res == 8'h00);
            end
            lfa_pkg::OP_ADD_IMMEDIATE: begin
               nxt_acc = add_sum;
               nxt_c   = add_c;
               nxt_dcy = add_dcy;
               nxt_z   = (add_sum == 8'h00);
            end
            lfa_pkg::OP_AND_FILE: begin
               res         = acc_ff & file_rd;
               res_to_dest = 1'b1;
               nxt_z       = (res == 8'h00);
            end
            lfa_pkg::OP_ADD_FILE,
            lfa_pkg::OP_ADD_FILE_WITH_CARRY: begin
               res         = add_sum;
               res_to_dest = 1'b1;
               nxt_c       = add_c;
               nxt_dcy     = add_dcy;
               nxt_z       = (add_sum == 8'h00);
            end
            lfa_pkg::OP_ARITH_SHIFT_RIGHT: begin
               res         = {file_rd[7], file_rd[7:1]};
               res_to_dest = 1'b1;
               nxt_c       = file_rd[0];
               nxt_z       = (res == 8'h00);
            end
            lfa_pkg::OP_BIT_CLEAR_FILE: begin
               // Written straight back, no destination choice and no flags
               res       = file_rd & ~(8'h01 << OP_BIT);
               mem_we    = 1'b1;
               mem_waddr = OP_FADDR;
               mem_wdata = res;
            end
            lfa_pkg::OP_POINTER_ADD_LITERAL: begin
               if (OP_PTR_SEL) begin
                  nxt_ptr1 = ptr_res;
               end else begin
                  nxt_ptr0 = ptr_res;
               end
            end
            default: nxt_done = 1'b0;
         endcase
         if (res_to_dest) begin
            if (OP_DEST) begin
               mem_we    = 1'b1;
               mem_waddr = OP_FADDR;
               mem_wdata = res;
            end else begin
               nxt_acc = res;
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         acc_ff   <= lfa_pkg::RST_ACC;
         c_ff     <= lfa_pkg::RST_FLAG;
         dcy_ff   <= lfa_pkg::RST_FLAG;
         z_ff     <= lfa_pkg::RST_FLAG;
         ptr0_ff  <= lfa_pkg::RST_PTR;
         ptr1_ff  <= lfa_pkg::RST_PTR;
         rdata_ff <= 32'h00000000;
         done_ff  <= 1'b0;
      end else begin
         acc_ff   <= nxt_acc;
         c_ff     <= nxt_c;
         dcy_ff   <= nxt_dcy;
         z_ff     <= nxt_z;
         ptr0_ff  <= nxt_ptr0;
         ptr1_ff  <= nxt_ptr1;
         rdata_ff <= nxt_rdata;
         done_ff  <= nxt_done;
      end
   end

   // File storage has no reset, as in a plain register file
   always_ff @(posedge CLK) begin
      if (mem_we) begin
         file_mem[mem_waddr] <= mem_wdata;
      end
   end

   // Every output is a register, never a path from the inputs
   assign RD_DATA = rdata_ff;
   assign ACC     = acc_ff;
   assign FLAG_C  = c_ff;
   assign FLAG_DCY = dcy_ff;
   assign FLAG_Z  = z_ff;
   assign PTR0    = ptr0_ff;
   assign PTR1    = ptr1_ff;
   assign OP_DONE = done_ff;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   logic is_op;
   logic [8:0] chk_sum;
   assign is_op   = OP_VALID;
   assign chk_sum = {1'b0, acc_ff} + {1'b0, file_rd} + {8'h00, c_ff};

   a_ptr0_wrap: assert property (
      is_op && OP_CODE == lfa_pkg::OP_POINTER_ADD_LITERAL && !OP_PTR_SEL
      |=> ptr0_ff == 16'($past(ptr0_ff) + {{10{$past(OP_LIT[5])}}, $past(OP_LIT[5:0])}))
      else $error("pointer pair 0 sum wrong");
   // A bus write to the status word may land beside an op, so checks that flags hold skip those cycles
   a_ptr_no_flags: assert property (
      is_op && OP_CODE == lfa_pkg::OP_POINTER_ADD_LITERAL && OP_PTR_SEL && !WR_EN
      |=> $stable({c_ff, dcy_ff, z_ff}) && ptr1_ff == 16'($past(ptr1_ff) + {{10{$past(OP_LIT[5])}}, $past(OP_LIT[5:0])}))
      else $error("pointer add touched flags or pair 1 wrong");
   a_and_imm_flags: assert property (
      is_op && OP_CODE == lfa_pkg::OP_AND_IMMEDIATE && !WR_EN
      |=> acc_ff == ($past(acc_ff) & $past(OP_LIT)) && z_ff == (acc_ff == 8'h00) && $stable({c_ff, dcy_ff}))
      else $error("and immediate result or flags wrong");
   a_add_imm_carry: assert property (
      is_op && OP_CODE == lfa_pkg::OP_ADD_IMMEDIATE
      |=> {c_ff, acc_ff} == {1'b0, $past(acc_ff)} + {1'b0, $past(OP_LIT)})
      else $error("add immediate sum or carry wrong");
   a_and_file_z: assert property (
      is_op && OP_CODE == lfa_pkg::OP_AND_FILE && !WR_EN
      |=> z_ff == (($past(acc_ff) & $past(file_rd)) == 8'h00) && $stable(c_ff))
      else $error("and file zero flag wrong");
   a_dest_acc_sel: assert property (
      is_op && OP_CODE == lfa_pkg::OP_ADD_FILE && OP_DEST && !WR_EN
      |=> $stable(acc_ff))
      else $error("destination 1 changed accumulator");
   a_add_file_sum: assert property (
      is_op && OP_CODE == lfa_pkg::OP_ADD_FILE && !OP_DEST
      |=> acc_ff == 8'($past(acc_ff) + $past(file_rd)))
      else $error("add file sum wrong");
   a_add_with_carry: assert property (
      is_op && OP_CODE == lfa_pkg::OP_ADD_FILE_WITH_CARRY && !OP_DEST
      |=> {c_ff, acc_ff} == $past(chk_sum))
      else $error("add with carry wrong");
   a_shift_carry: assert property (
      is_op && OP_CODE == lfa_pkg::OP_ARITH_SHIFT_RIGHT && !OP_DEST
      |=> c_ff == $past(file_rd[0]) && acc_ff[7:6] == {2{$past(file_rd[7])}})
      else $error("shift right wrong");
   a_bit_clear_kept: assert property (
      is_op && OP_CODE == lfa_pkg::OP_BIT_CLEAR_FILE && !WR_EN
      |=> $stable({c_ff, dcy_ff, z_ff, acc_ff}))
      else $error("bit clear changed flags");
   a_digit_carry: assert property (
      is_op && OP_CODE == lfa_pkg::OP_ADD_IMMEDIATE
      |=> dcy_ff == ({1'b0, $past(acc_ff[3:0])} + {1'b0, $past(OP_LIT[3:0])} > 5'h0F))
      else $error("digit carry wrong");

   // Destination, file write-back and pulse checks
   logic       upd_z;
   logic [7:0] clr_mask;
   assign upd_z    = is_op && (OP_CODE != lfa_pkg::OP_BIT_CLEAR_FILE)
                     && (OP_CODE != lfa_pkg::OP_POINTER_ADD_LITERAL);
   assign clr_mask = 8'h01 << OP_BIT;

   a_bit_clear_bit: assert property (
      is_op && OP_CODE == lfa_pkg::OP_BIT_CLEAR_FILE
      |-> mem_we && mem_waddr == OP_FADDR && !mem_wdata[OP_BIT] && (mem_wdata | clr_mask) == (file_rd | clr_mask))
      else $error("bit clear write wrong");
   a_and_file_dest: assert property (
      is_op && OP_CODE == lfa_pkg::OP_AND_FILE && OP_DEST
      |-> mem_we && mem_waddr == OP_FADDR && mem_wdata == (acc_ff & file_rd))
      else $error("and file write back wrong");
   a_shift_to_file: assert property (
      is_op && OP_CODE == lfa_pkg::OP_ARITH_SHIFT_RIGHT && OP_DEST
      |-> mem_we && mem_waddr == OP_FADDR && mem_wdata[7] == file_rd[7] && mem_wdata[6:0] == file_rd[7:1])
      else $error("shift write back wrong");
   a_zero_to_acc: assert property (
      upd_z && (!OP_DEST || OP_CODE == lfa_pkg::OP_AND_IMMEDIATE || OP_CODE == lfa_pkg::OP_ADD_IMMEDIATE)
      |=> z_ff == (acc_ff == 8'h00))
      else $error("zero flag does not match result");
   a_add_file_carry: assert property (
      is_op && OP_CODE == lfa_pkg::OP_ADD_FILE && !OP_DEST
      |=> {c_ff, acc_ff} == {1'b0, $past(acc_ff)} + {1'b0, $past(file_rd)})
      else $error("add file carry wrong");
   a_carry_digit: assert property (
      is_op && OP_CODE == lfa_pkg::OP_ADD_FILE_WITH_CARRY
      |=> dcy_ff == ({1'b0, $past(acc_ff[3:0])} + {1'b0, $past(file_rd[3:0])} + {4'h0, $past(c_ff)} > 5'h0F))
      else $error("digit carry with carry wrong");
   a_ptr_other_kept: assert property (
      is_op && OP_CODE == lfa_pkg::OP_POINTER_ADD_LITERAL && !OP_PTR_SEL && !WR_EN
      |=> $stable(ptr1_ff))
      else $error("pointer add changed pair 1");
   a_ptr0_kept: assert property (
      is_op && OP_CODE == lfa_pkg::OP_POINTER_ADD_LITERAL && OP_PTR_SEL && !WR_EN
      |=> $stable(ptr0_ff))
      else $error("pointer add changed pair 0");
   a_done_pulse: assert property (
      OP_VALID |=> done_ff)
      else $error("done missing after operation");
   a_done_quiet: assert property (
      !OP_VALID |=> !done_ff)
      else $error("done without operation");
   a_read_idle: assert property (
      !RD_EN |=> rdata_ff == 32'h00000000)
      else $error("read data not cleared");

   c_add_carry_out: cover property (is_op && OP_CODE == lfa_pkg::OP_ADD_IMMEDIATE ##1 c_ff);
   c_ptr_wrap_low:  cover property (is_op && OP_CODE == lfa_pkg::OP_POINTER_ADD_LITERAL && ptr0_ff == 16'h0000
                                    && OP_LIT[5] && !OP_PTR_SEL);
   c_file_dest:     cover property (is_op && OP_CODE == lfa_pkg::OP_AND_FILE && OP_DEST);
   c_read_back:     cover property (RD_EN && bus_in_file);
   c_shift_to_file: cover property (is_op && OP_CODE == lfa_pkg::OP_ARITH_SHIFT_RIGHT && OP_DEST && file_rd[7]);
endmodule

// file: logic/lfa_pkg.sv
// Shared constants, register map and operation codes for the accumulator and pointer datapath
// How it works
// - Pointer add sums a signed literal from -32 to 31 into the pointer pair picked by one index bit, flags untouched.
// - The pointer pair result wraps modulo 65536 inside 0000h to FFFFh.
// - AND immediate puts accumulator AND literal into the accumulator and updates only zero.
// - Add immediate puts accumulator plus literal into the accumulator and updates carry, digit carry and zero.
// - AND file ANDs the accumulator with file register 0 to 127 and updates only zero.
// - For AND file, add file, add file with carry and shift right the destination bit 0 writes the accumulator and 1 writes the file register back.
// - Add file sums accumulator and file register into the destination and updates carry, digit carry, zero.
// - Add file with carry also adds the current carry and updates carry, digit carry and zero.
// - Arithmetic shift right keeps bit 7, moves bits 7:1 to 6:0, bit 0 to carry, and updates carry and zero.
// - Bit clear zeroes the chosen bit 0 to 7 of the file register, keeps the rest and touches no flag.
package lfa_pkg;

   typedef enum logic [2:0] {
      OP_AND_IMMEDIATE,
      OP_ADD_IMMEDIATE,
      OP_AND_FILE,
      OP_ADD_FILE,
      OP_ADD_FILE_WITH_CARRY,
      OP_ARITH_SHIFT_RIGHT,
      OP_BIT_CLEAR_FILE,
      OP_POINTER_ADD_LITERAL
   } lfa_op_t;

   localparam int          DATA_W      = 8;
   localparam int          PTR_W       = 16;
   localparam int          FADDR_W     = 7;
   localparam int          FILE_DEPTH  = 128;
   localparam int          BUS_ADDR_W  = 10;
   localparam int          BUS_DATA_W  = 32;
   localparam int          PLIT_W      = 6;

   localparam logic [9:0]  OFS_ACC     = 10'h000;
   localparam logic [9:0]  OFS_STATUS  = 10'h004;
   localparam logic [9:0]  OFS_PTR0    = 10'h008;
   localparam logic [9:0]  OFS_PTR1    = 10'h00C;
   localparam logic [9:0]  OFS_FILE    = 10'h200;

   localparam int          POS_C       = 0;
   localparam int          POS_DCY     = 1;
   localparam int          POS_Z       = 2;

   localparam logic [7:0]  RST_ACC     = 8'h00;
   localparam logic [15:0] RST_PTR     = 16'h0000;
   localparam logic        RST_FLAG    = 1'b0;

endpackage

// file: logic/lfa_add8.sv
// Eight-bit adder with carry in, carry out of bit 7 and carry out of bit 3
module lfa_add8 (
   input  wire logic [7:0] a,
   input  wire logic [7:0] b,
   input  wire logic       cin,
   output logic      [7:0] sum,
   output logic            cout,
   output logic            dcout
);
   logic [8:0] full;
   logic [4:0] low;

   always_comb begin
      full  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      sum   = full[7:0];
      cout  = full[8];
      dcout = low[4];
   end
endmodule

// file: logic/lfa_ptr_add.sv
// Pointer pair plus signed six-bit literal, wrapping inside sixteen bits
module lfa_ptr_add (
   input  wire logic [15:0] ptr,
   input  wire logic [5:0]  lit,
   output logic      [15:0] res
);
   always_comb begin
      // Sign extension then a plain 16-bit sum drops the carry, so both ends wrap
      res = ptr + {{10{lit[5]}}, lit};
   end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the accumulator, flag and pointer datapath
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
   $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic             clk, rst_n, op_valid, op_dest, op_ptr_sel, wr_en, rd_en, op_seen, rd_seen;
   lfa_pkg::lfa_op_t op_code;
   logic [7:0]       op_lit, acc, mf [128], ma;
   logic [6:0]       op_faddr;
   logic [2:0]       op_bit;
   logic [9:0]       addr;
   logic [31:0]      wr_data, rd_data;
   logic             flag_c, flag_dcy, flag_z, op_done, mc, mdc, mz;
   logic [15:0]      ptr0, ptr1, mp0, mp1;
   logic [42:0]      op_q [$];
   logic [31:0]      rd_q [$];
   logic [42:0]      exp_op;
   logic [31:0]      exp_rd;
   int               num_errors, comparisons;

   lfa_core i_lfa_core (.CLK(clk), .RST_N(rst_n), .OP_VALID(op_valid), .OP_CODE(op_code), .OP_LIT(op_lit),
      .OP_FADDR(op_faddr), .OP_DEST(op_dest), .OP_BIT(op_bit), .OP_PTR_SEL(op_ptr_sel), .ADDR(addr),
      .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .ACC(acc), .FLAG_C(flag_c),
      .FLAG_DCY(flag_dcy), .FLAG_Z(flag_z), .PTR0(ptr0), .PTR1(ptr1), .OP_DONE(op_done));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic final_report();
      $display("checks %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Reference model, updated when a request is issued so back-to-back ops chain
   task automatic model(lfa_pkg::lfa_op_t op, logic [7:0] lit, logic [6:0] fa, logic d, logic [2:0] bt, logic ps);
      logic [7:0] f, b, r;
      logic [8:0] s;
      logic [4:0] h;
      logic       ci;
      f = mf[fa];
      b = (op == lfa_pkg::OP_ADD_IMMEDIATE) ? lit : f;
      ci = (op == lfa_pkg::OP_ADD_FILE_WITH_CARRY) ? mc : 1'b0;
      r = 8'h00;
      case (op)
         lfa_pkg::OP_AND_IMMEDIATE: r = ma & lit;
         lfa_pkg::OP_AND_FILE: r = ma & f;
         lfa_pkg::OP_ADD_IMMEDIATE, lfa_pkg::OP_ADD_FILE, lfa_pkg::OP_ADD_FILE_WITH_CARRY: begin
            s = ma + b + ci;
            h = ma[3:0] + b[3:0] + ci;
            r = s[7:0];
            mc = s[8];
            mdc = h[4];
         end
         lfa_pkg::OP_ARITH_SHIFT_RIGHT: begin
            r = {f[7], f[7:1]};
            mc = f[0];
         end
         lfa_pkg::OP_BIT_CLEAR_FILE: begin
            f[bt] = 1'b0;
            mf[fa] = f;
         end
         default: begin
            if (ps) mp1 = mp1 + {{10{lit[5]}}, lit[5:0]};
            else mp0 = mp0 + {{10{lit[5]}}, lit[5:0]};
         end
      endcase
      if (op != lfa_pkg::OP_BIT_CLEAR_FILE && op != lfa_pkg::OP_POINTER_ADD_LITERAL) begin
         mz = (r == 8'h00);
         if (d && op != lfa_pkg::OP_AND_IMMEDIATE && op != lfa_pkg::OP_ADD_IMMEDIATE) mf[fa] = r;
         else ma = r;
      end
   endtask

   task automatic drive(logic v, lfa_pkg::lfa_op_t op, logic [7:0] lit, logic [6:0] fa, logic d, logic [2:0] bt,
                        logic ps);
      @(posedge clk);
      op_valid <= v;
      op_code <= op;
      op_lit <= lit;
      op_faddr <= fa;
      op_dest <= d;
      op_bit <= bt;
      op_ptr_sel <= ps;
      if (v) begin
         model(op, lit, fa, d, bt, ps);
         op_q.push_back({ma, mc, mdc, mz, mp0, mp1});
      end
   endtask

   task automatic bus_wr(logic [9:0] a, logic [31:0] dat);
      @(posedge clk);
      addr <= a;
      wr_data <= dat;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   task automatic bus_rd(logic [9:0] a, logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      rd_q.push_back(exp);
      @(posedge clk);
      rd_en <= 1'b0;
   endtask

   always @(posedge clk) begin
      op_seen <= op_valid;
      rd_seen <= rd_en;
   end

   // Results are settled by the falling edge
   always @(negedge clk) begin
      if (rst_n) begin
         `CHK(op_done, op_seen, "done pulse")
         if (op_seen) begin
            // Popped once into a variable; an empty queue gives unknown and so a mismatch
            exp_op = (op_q.size() > 0) ? op_q.pop_front() : 'x;
            `CHK({acc, flag_c, flag_dcy, flag_z, ptr0, ptr1}, exp_op, "state")
         end
         if (rd_seen) begin
            exp_rd = (rd_q.size() > 0) ? rd_q.pop_front() : 'x;
            `CHK(rd_data, exp_rd, "read")
         end else begin
            `CHK(rd_data, 32'h0, "idle read data")
         end
      end
   end

   initial begin
      #100000;
      num_errors++;
      final_report();
   end

   initial begin
      logic [7:0] v;
      rst_n = 1'b0;
      {op_valid, op_dest, op_ptr_sel, wr_en, rd_en} = '0;
      op_code = lfa_pkg::OP_AND_IMMEDIATE;
      {op_lit, op_faddr, op_bit, addr, wr_data} = '0;
      {ma, mc, mdc, mz, mp0, mp1} = '0;
      void'($urandom(90));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK({acc, flag_c, flag_dcy, flag_z, ptr0, ptr1, op_done}, 44'h0, "reset state")
      bus_rd(lfa_pkg::OFS_ACC, 32'h0);
      bus_rd(lfa_pkg::OFS_STATUS, 32'h0);
      bus_rd(lfa_pkg::OFS_PTR1, 32'h0);
      for (int i = 0; i < 128; i++) begin
         mf[i] = 8'($urandom);
         bus_wr(lfa_pkg::OFS_FILE + 10'(4 * i), {24'h0, mf[i]});
      end
      bus_wr(10'h010, 32'hFFFF_FFFF);
      bus_rd(10'h010, 32'h0);
      bus_rd(10'h202, 32'h0);
      // Pointer wrap at both ends
      mp0 = 16'hFFFF;
      bus_wr(lfa_pkg::OFS_PTR0, 32'h0000_FFFF);
      drive(1, lfa_pkg::OP_POINTER_ADD_LITERAL, 8'h01, 7'h0, 0, 0, 0);
      drive(1, lfa_pkg::OP_POINTER_ADD_LITERAL, 8'h20, 7'h0, 0, 0, 1);
      drive(1, lfa_pkg::OP_POINTER_ADD_LITERAL, 8'h1F, 7'h0, 0, 0, 1);
      drive(0, lfa_pkg::OP_AND_IMMEDIATE, 8'h0, 7'h0, 0, 0, 0);
      // Digit carry and carry boundaries
      for (int i = 0; i < 3; i++) begin
         v = (i == 0) ? 8'h0F : (i == 1) ? 8'hFF : 8'h70;
         ma = v;
         bus_wr(lfa_pkg::OFS_ACC, {24'h0, v});
         drive(1, lfa_pkg::OP_ADD_IMMEDIATE, 8'h01 << (i * 2), 7'h0, 0, 0, 0);
         drive(1, lfa_pkg::OP_AND_IMMEDIATE, 8'h00, 7'h0, 0, 0, 0);
         drive(0, lfa_pkg::OP_AND_IMMEDIATE, 8'h0, 7'h0, 0, 0, 0);
      end
      {mc, mdc, mz} = 3'b101;
      bus_wr(lfa_pkg::OFS_STATUS, 32'h0000_0005);
      for (int i = 0; i < 600; i++) begin
         drive($urandom_range(3, 0) != 0, lfa_pkg::lfa_op_t'($urandom_range(7, 0)), 8'($urandom),
               7'($urandom), 1'($urandom), 3'($urandom), 1'($urandom));
      end
      drive(0, lfa_pkg::OP_AND_IMMEDIATE, 8'h0, 7'h0, 0, 0, 0);
      for (int i = 0; i < 128; i++) begin
         bus_rd(lfa_pkg::OFS_FILE + 10'(4 * i), {24'h0, mf[i]});
      end
      bus_rd(lfa_pkg::OFS_STATUS, {29'h0, mz, mdc, mc});
      bus_rd(lfa_pkg::OFS_PTR0, {16'h0, mp0});
      repeat (3) @(posedge clk);
      `CHK(op_q.size() + rd_q.size(), 0, "pending results")
      final_report();
   end
endmodule
